// file: rtl/dsem_map.svh
// register offsets, field positions, reset values and timing counts for the semaphore port controller
// assumes a 100 MHz pclk; included by bare name
`ifndef DSEM_MAP_SVH
`define DSEM_MAP_SVH
// register byte offsets
`define DSEM_CTRL_OFS 12'h000
`define DSEM_POLL_OFS 12'h004
`define DSEM_STAT_OFS 12'h008
`define DSEM_RDAT_OFS 12'h00C
`define DSEM_CFG_OFS 12'h010
// control fields
`define DSEM_CTRL_GO 0
`define DSEM_CTRL_OP_LO 1
`define DSEM_CTRL_IDX_LO 4
`define DSEM_CTRL_RETRY 8
// status fields
`define DSEM_STAT_BUSY 0
`define DSEM_STAT_DONE 1
`define DSEM_STAT_WON 2
`define DSEM_STAT_OWN_LO 8
// reset values
`define DSEM_POLL_RST 8'h10
`define DSEM_CFG_RST 1'b0
// timing in ns and derived cycle counts (least times round up)
`define DSEM_CLK_NS 10
`define DSEM_SETUP_NS 20
`define DSEM_WPULSE_NS 30
`define DSEM_ACCESS_NS 40
`define DSEM_GAP_NS 20
`define DSEM_SETUP_CYC ((`DSEM_SETUP_NS + `DSEM_CLK_NS - 1) / `DSEM_CLK_NS)
`define DSEM_WPULSE_CYC ((`DSEM_WPULSE_NS + `DSEM_CLK_NS - 1) / `DSEM_CLK_NS)
`define DSEM_ACCESS_CYC ((`DSEM_ACCESS_NS + `DSEM_CLK_NS - 1) / `DSEM_CLK_NS)
`define DSEM_GAP_CYC ((`DSEM_GAP_NS + `DSEM_CLK_NS - 1) / `DSEM_CLK_NS)
// pin synchroniser latency in cycles, added to every read wait
`define DSEM_SYNC_CYC 3
`endif

// file: rtl/dsem_pkg.sv
// types shared by the semaphore port controller and its bench
// assumes nothing beyond the map header for numbers
package dsem_pkg;
	// pins of one ram port, driven by the controller
	typedef struct packed {
		logic token_flag_select_n;
		logic ce_n;
		logic rw_n;
		logic oe_n;
		logic [2:0] flag_index_lines;
		logic [17:0] dq_out;
		logic dq_oe_n;
	} dsem_pins_t;
	// operations software can start
	typedef enum logic [1:0] {
		DSEM_OP_ACQ = 2'b00,
		DSEM_OP_REL = 2'b01,
		DSEM_OP_INIT = 2'b10,
		DSEM_OP_READ = 2'b11
	} dsem_op_t;
	// sequencer states
	typedef enum logic [2:0] {
		DSEM_IDLE = 3'b000,
		DSEM_WSET = 3'b001,
		DSEM_WPUL = 3'b010,
		DSEM_WREC = 3'b011,
		DSEM_RACC = 3'b100,
		DSEM_GAP = 3'b101,
		DSEM_FIN = 3'b110
	} dsem_state_t;
endpackage : dsem_pkg

// file: rtl/dsem_host.sv
// controller driving one port of a dual-port ram semaphore block, with an apb register file
// assumes the ram port pins are asynchronous to pclk; busy comes from the array master
`timescale 1ns/10ps
`include "dsem_map.svh"

// Behaviour
// - only one ram per address range may be strapped master
// - address and enables held stable a setup time before write pulse
// - flags active low: write zero requests, write one releases
// - select and output enable drop between successive poll reads
// - acquire writes zero first, then reads back to confirm
// - failed acquire keeps polling or writes one to withdraw
// - init writes one to all eight flags
module dsem_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output dsem_pkg::dsem_pins_t pins,
	input wire logic [17:0] dq_in,
	input wire logic busy_n,
	output logic role_master
);
	// ==========================================================
	// pin input synchronisers
	logic [17:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
	logic busy_s1_reg, busy_s2_reg, busy_s3_reg;
	logic busy_seen_reg;
	// second and third stages act as agreement check, never the first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq_s1_reg <= 18'h00000;
			dq_s2_reg <= 18'h00000;
			dq_s3_reg <= 18'h00000;
			busy_s1_reg <= 1'b1;
			busy_s2_reg <= 1'b1;
			busy_s3_reg <= 1'b1;
		end else begin
			dq_s1_reg <= dq_in;
			dq_s2_reg <= dq_s1_reg;
			dq_s3_reg <= dq_s2_reg;
			busy_s1_reg <= busy_n;
			busy_s2_reg <= busy_s1_reg;
			busy_s3_reg <= busy_s2_reg;
		end
	end

	// busy level changes only once two stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_seen_reg <= 1'b0;
		end else if (busy_s2_reg == busy_s3_reg) begin
			busy_seen_reg <= !busy_s3_reg;
		end
	end

	// ==========================================================
	// register file
	logic [7:0] poll_limit_reg;
	logic cfg_master_reg;
	logic done_reg;
	logic won_reg;
	logic [7:0] own_reg;
	logic [17:0] rdat_reg;
	logic [31:0] prdata_reg;
	logic go_pulse;
	logic [1:0] op_field;
	logic [2:0] idx_field;
	logic retry_field;
	logic wr_acc;
	logic mapped;
	logic busy;
	logic fin_evt;

	assign wr_acc = psel && penable && pwrite;
	assign mapped = (paddr == `DSEM_CTRL_OFS) || (paddr == `DSEM_POLL_OFS) || (paddr == `DSEM_STAT_OFS)
		|| (paddr == `DSEM_RDAT_OFS) || (paddr == `DSEM_CFG_OFS);
	assign op_field = pwdata[`DSEM_CTRL_OP_LO +: 2];
	assign idx_field = pwdata[`DSEM_CTRL_IDX_LO +: 3];
	assign retry_field = pwdata[`DSEM_CTRL_RETRY];
	// start is ignored while a sequence runs
	assign go_pulse = wr_acc && (paddr == `DSEM_CTRL_OFS) && pwdata[`DSEM_CTRL_GO] && !busy;
	// zero wait states; unmapped offsets answer with an error
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_reg;
	assign role_master = cfg_master_reg;

	// software writable settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			poll_limit_reg <= `DSEM_POLL_RST;
			cfg_master_reg <= `DSEM_CFG_RST;
		end else if (wr_acc) begin
			if (paddr == `DSEM_POLL_OFS) begin
				poll_limit_reg <= pwdata[7:0];
			end
			if (paddr == `DSEM_CFG_OFS) begin
				cfg_master_reg <= pwdata[0];
			end
		end
	end

	// done is sticky; completion wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= 1'b0;
		end else if (fin_evt) begin
			done_reg <= 1'b1;
		end else if (go_pulse || (wr_acc && (paddr == `DSEM_STAT_OFS) && pwdata[`DSEM_STAT_DONE])) begin
			done_reg <= 1'b0;
		end
	end

	// read data captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else if (psel && !penable) begin
			case (paddr)
				`DSEM_POLL_OFS: prdata_reg <= {24'h000000, poll_limit_reg};
				`DSEM_STAT_OFS: prdata_reg <= {16'h0000, own_reg, 5'h00, won_reg, done_reg, busy};
				`DSEM_RDAT_OFS: prdata_reg <= {14'h0000, rdat_reg};
				`DSEM_CFG_OFS: prdata_reg <= {31'h00000000, cfg_master_reg};
				default: prdata_reg <= 32'h00000000;
			endcase
		end
	end

	// ==========================================================
	// port sequencer
	dsem_pkg::dsem_state_t state_reg;
	dsem_pkg::dsem_op_t op_reg;
	logic [2:0] idx_reg;
	logic retry_reg;
	logic wval_reg;
	logic [3:0] cnt_reg;
	logic [7:0] polls_reg;
	logic read_zero;
	logic read_stable;

	assign busy = (state_reg != dsem_pkg::DSEM_IDLE);
	assign fin_evt = (state_reg == dsem_pkg::DSEM_FIN);
	assign read_stable = (dq_s2_reg == dq_s3_reg);
	// flag is copied to every bit; bit zero suffices once stable
	assign read_zero = !dq_s3_reg[0];

	// state, counters and latched command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= dsem_pkg::DSEM_IDLE;
			op_reg <= dsem_pkg::DSEM_OP_ACQ;
			idx_reg <= 3'h0;
			retry_reg <= 1'b0;
			wval_reg <= 1'b1;
			cnt_reg <= 4'h0;
			polls_reg <= 8'h00;
		end else begin
			case (state_reg)
				dsem_pkg::DSEM_IDLE: begin
					if (go_pulse) begin
						op_reg <= dsem_pkg::dsem_op_t'(op_field);
						idx_reg <= (op_field == dsem_pkg::DSEM_OP_INIT) ? 3'h0 : idx_field;
						retry_reg <= retry_field;
						polls_reg <= 8'h00;
						cnt_reg <= 4'h0;
						// acquire writes zero before any read
						wval_reg <= (op_field != dsem_pkg::DSEM_OP_ACQ);
						state_reg <= (op_field == dsem_pkg::DSEM_OP_READ) ? dsem_pkg::DSEM_RACC
							: dsem_pkg::DSEM_WSET;
					end
				end
				dsem_pkg::DSEM_WSET: begin
					// hold address and enables, and wait out a slave write inhibit
					if (busy_seen_reg) begin
						cnt_reg <= 4'h0;
					end else if (cnt_reg == 4'(`DSEM_SETUP_CYC - 1)) begin
						cnt_reg <= 4'h0;
						state_reg <= dsem_pkg::DSEM_WPUL;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				dsem_pkg::DSEM_WPUL: begin
					if (cnt_reg == 4'(`DSEM_WPULSE_CYC - 1)) begin
						cnt_reg <= 4'h0;
						state_reg <= dsem_pkg::DSEM_WREC;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				dsem_pkg::DSEM_WREC: begin
					cnt_reg <= 4'h0;
					if (op_reg == dsem_pkg::DSEM_OP_INIT && idx_reg != 3'h7) begin
						idx_reg <= idx_reg + 3'h1;
						state_reg <= dsem_pkg::DSEM_WSET;
					end else if (op_reg == dsem_pkg::DSEM_OP_ACQ && !wval_reg) begin
						state_reg <= dsem_pkg::DSEM_RACC;
					end else begin
						state_reg <= dsem_pkg::DSEM_FIN;
					end
				end
				dsem_pkg::DSEM_RACC: begin
					// access time plus synchroniser delay, else the chain still shows the old bus
					if (cnt_reg < 4'(`DSEM_ACCESS_CYC + `DSEM_SYNC_CYC)) begin
						cnt_reg <= cnt_reg + 4'h1;
					end else if (read_stable) begin
						cnt_reg <= 4'h0;
						if (op_reg != dsem_pkg::DSEM_OP_ACQ || read_zero) begin
							state_reg <= dsem_pkg::DSEM_FIN;
						end else if (retry_reg && polls_reg != poll_limit_reg) begin
							polls_reg <= polls_reg + 8'h1;
							state_reg <= dsem_pkg::DSEM_GAP;
						end else begin
							wval_reg <= 1'b1;
							state_reg <= dsem_pkg::DSEM_WSET;
						end
					end
				end
				dsem_pkg::DSEM_GAP: begin
					// select and output enable stay high so the port relatches
					if (cnt_reg == 4'(`DSEM_GAP_CYC - 1)) begin
						cnt_reg <= 4'h0;
						state_reg <= dsem_pkg::DSEM_RACC;
					end else begin
						cnt_reg <= cnt_reg + 4'h1;
					end
				end
				dsem_pkg::DSEM_FIN: begin
					state_reg <= dsem_pkg::DSEM_IDLE;
				end
				default: begin
					state_reg <= dsem_pkg::DSEM_IDLE;
				end
			endcase
		end
	end

	// last read word and acquire outcome; ownership map is software bookkeeping only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdat_reg <= 18'h00000;
			won_reg <= 1'b0;
			own_reg <= 8'h00;
		end else if (state_reg == dsem_pkg::DSEM_RACC && read_stable
			&& cnt_reg >= 4'(`DSEM_ACCESS_CYC + `DSEM_SYNC_CYC)) begin
			rdat_reg <= dq_s3_reg;
			won_reg <= read_zero;
			own_reg[idx_reg] <= read_zero;
		end else if (state_reg == dsem_pkg::DSEM_WREC && wval_reg) begin
			won_reg <= 1'b0;
			own_reg[idx_reg] <= 1'b0;
		end
	end

	// ==========================================================
	// port pin drive, all from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins <= '{token_flag_select_n: 1'b1, ce_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1,
				flag_index_lines: 3'h0, dq_out: 18'h00000, dq_oe_n: 1'b1};
		end else begin
			// ram chip enable never asserted: only flag space is used
			pins.ce_n <= 1'b1;
			pins.flag_index_lines <= idx_reg;
			// only bit zero matters to the flag; drive it across for clarity
			pins.dq_out <= {18{wval_reg}};
			case (state_reg)
				dsem_pkg::DSEM_WSET, dsem_pkg::DSEM_WPUL: begin
					pins.token_flag_select_n <= 1'b0;
					pins.oe_n <= 1'b1;
					pins.dq_oe_n <= 1'b0;
					pins.rw_n <= !(state_reg == dsem_pkg::DSEM_WPUL);
				end
				dsem_pkg::DSEM_RACC: begin
					pins.token_flag_select_n <= 1'b0;
					pins.oe_n <= 1'b0;
					pins.rw_n <= 1'b1;
					pins.dq_oe_n <= 1'b1;
				end
				default: begin
					// standby between cycles; also ends each poll read
					pins.token_flag_select_n <= 1'b1;
					pins.oe_n <= 1'b1;
					pins.rw_n <= 1'b1;
					pins.dq_oe_n <= (state_reg == dsem_pkg::DSEM_WREC) ? 1'b0 : 1'b1;
				end
			endcase
		end
	end
endmodule : dsem_host

// file: test/dsem_checker.sv
// assertions on the ram pins and apb answers of the semaphore port controller
// assumes it is bound to dsem_host and sees only that module's ports
`timescale 1ns/10ps
module dsem_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pslverr,
	input wire dsem_pkg::dsem_pins_t pins,
	input wire logic busy_n
);
	// ========
	// properties
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// a write strobe is three cycles low, then released
	sequence strobe_s;
		!pins.rw_n [*3] ##1 pins.rw_n;
	endsequence
	ram_standby_a: assert property (pins.ce_n)
		else $error("ram enable driven low");
	strobe_len_a: assert property ($fell(pins.rw_n) |-> strobe_s)
		else $error("write strobe length wrong");
	addr_setup_a: assert property ($fell(pins.rw_n) |-> $past(pins.token_flag_select_n, 2) == 1'b0)
		else $error("strobe without select setup");
	busy_defer_a: assert property (!busy_n [*6] |=> !$fell(pins.rw_n))
		else $error("strobe started while busy");
	strobe_qual_a: assert property (!pins.rw_n |-> !pins.token_flag_select_n && !pins.dq_oe_n && pins.oe_n)
		else $error("strobe without select or data");
	data_copy_a: assert property (!pins.dq_oe_n |-> pins.dq_out == 18'h00000 || pins.dq_out == 18'h3FFFF)
		else $error("write data not uniform");
	index_hold_a: assert property (!pins.token_flag_select_n && !$past(pins.token_flag_select_n)
		|-> $stable(pins.flag_index_lines))
		else $error("index moved while selected");
	poll_gap_a: assert property ($rose(pins.oe_n) |-> pins.oe_n [*2])
		else $error("read enable gap too short");
	read_float_a: assert property (!pins.oe_n |-> pins.dq_oe_n)
		else $error("data driven during read");
	err_phase_a: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
endmodule : dsem_checker

// file: test/dsem_ram_model.sv
// behavioural semaphore space of the dual-port ram: near port on pins, far port by task
// assumes the bench plays the far processor through far_wr
`timescale 1ns/10ps
module dsem_ram_model (
	input wire dsem_pkg::dsem_pins_t pins,
	input wire logic role_master,
	input wire logic slave_busy_n,
	output logic [17:0] dq_in,
	output logic busy_n
);
	// ========
	// flag state: owner 0 free, 1 near, 2 far; req holds a pending zero
	logic [1:0] owner [8];
	logic [7:0] req [3];
	logic lat;
	int lag;
	// latches start dirty, so software must clear them
	initial begin
		foreach (owner[i]) owner[i] = 2'h1;
		req[1] = 8'hFF;
		req[2] = 8'h00;
		lat = 1'h0;
		lag = 0;
		dq_in = 18'h00000;
	end
	// master never sees a ram address match here, slave passes the bench level
	assign busy_n = role_master ? 1'h1 : slave_busy_n;
	// one flag update from either side
	task automatic sem_wr(input logic [1:0] s, input logic [2:0] i, input logic b);
		req[s][i] = !b;
		if (!b && owner[i] == 2'h0)
			owner[i] = s;
		else if (b && owner[i] == s)
			owner[i] = req[s ^ 2'h3][i] ? s ^ 2'h3 : 2'h0;
	endtask : sem_wr
	// far port never waits on the near one, and gates nothing
	task automatic far_wr(input logic [2:0] i, input logic b);
		sem_wr(2'h2, i, b);
	endtask : far_wr
	// near write at strobe start, dropped while busy is low
	always @(negedge pins.rw_n) if (!pins.token_flag_select_n && busy_n) begin
		sem_wr(2'h1, pins.flag_index_lines, pins.dq_out[0]);
	end
	// read value frozen when select and output enable both go low
	always @(negedge (pins.token_flag_select_n | pins.oe_n)) begin
		lat = owner[pins.flag_index_lines] != 2'h1;
	end
	// released lines show the inverse of the coming read, so an early sample is caught
	always @(pins, lat, lag) begin
		dq_in <= #(lag) (!pins.token_flag_select_n && !pins.oe_n) ? {18{lat}}
			: {18{owner[pins.flag_index_lines] == 2'h1}};
	end
endmodule : dsem_ram_model

// file: test/dsem_host_test.sv
// self-checking bench for the semaphore port controller over apb
// assumes the ram model stands on the port pins and plays the far processor
`timescale 1ns/10ps
`include "dsem_map.svh"
module dsem_host_test;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	dsem_pkg::dsem_pins_t pins;
	logic [17:0] dq_in;
	logic busy_n;
	logic role_master;
	logic slave_busy_n = 1'h1;
	logic [31:0] rd;
	logic err;
	int errors = 0;
	int check_count = 0;
	always #5 pclk = ~pclk;
	dsem_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pins(pins), .dq_in(dq_in), .busy_n(busy_n), .role_master(role_master));
	dsem_ram_model ram (.pins(pins), .role_master(role_master), .slave_busy_n(slave_busy_n),
		.dq_in(dq_in), .busy_n(busy_n));
	// ========
	// tasks
	task automatic summarize();
		$display("mismatches %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one apb transfer; read data and error taken at the pready edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 50);
		if (n >= 50) begin
			errors++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	// start an operation, then poll status until done; rd ends as status
	task automatic go(input logic [1:0] op, input logic [2:0] i, input logic retry);
		int n;
		apb(1'h1, `DSEM_CTRL_OFS, {23'h000000, retry, 1'h0, i, 1'h0, op, 1'h1});
		n = 0;
		do begin
			apb(1'h0, `DSEM_STAT_OFS, 32'h0);
			n++;
		end while (rd[1] !== 1'h1 && n < 300);
		if (n >= 300) begin
			errors++;
			summarize();
		end
	endtask : go
	// ========
	// scenarios
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, `DSEM_POLL_OFS, 32'h0);
		chk("poll reset", 32'h00000010, rd);
		apb(1'h0, 12'h014, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		go(2'h2, 3'h0, 1'h0);
		for (int i = 0; i < 8; i++) chk("flag free", 32'h0, {30'h0, ram.owner[i]});
		go(2'h0, 3'h3, 1'h0);
		chk("acquire status", 32'h00000806, rd & 32'h0000FF07);
		apb(1'h0, `DSEM_RDAT_OFS, 32'h0);
		chk("acquire read", 32'h0, rd);
		ram.far_wr(3'h5, 1'h0);
		go(2'h0, 3'h5, 1'h0);
		chk("refused status", 32'h00000802, rd & 32'h0000FF07);
		apb(1'h0, `DSEM_RDAT_OFS, 32'h0);
		chk("refused read", 32'h0003FFFF, rd);
		chk("withdrawn", 32'h0, {31'h0, ram.req[1][5]});
		ram.far_wr(3'h5, 1'h1);
		chk("freed", 32'h0, {30'h0, ram.owner[5]});
		apb(1'h1, `DSEM_POLL_OFS, 32'h00000040);
		ram.far_wr(3'h6, 1'h0);
		fork
			begin
				repeat (60) @(posedge pclk);
				ram.far_wr(3'h6, 1'h1);
			end
		join_none
		go(2'h0, 3'h6, 1'h1);
		chk("retry status", 32'h00004806, rd & 32'h0000FF07);
		go(2'h1, 3'h3, 1'h0);
		chk("release status", 32'h00004002, rd & 32'h0000FF03);
		chk("released", 32'h0, {30'h0, ram.owner[3]});
		ram.lag = 25;
		ram.far_wr(3'h2, 1'h0);
		go(2'h3, 3'h2, 1'h0);
		apb(1'h0, `DSEM_RDAT_OFS, 32'h0);
		chk("slow read", 32'h0003FFFF, rd);
		ram.lag = 0;
		slave_busy_n <= 1'h0;
		fork
			begin
				repeat (40) @(posedge pclk);
				slave_busy_n <= 1'h1;
			end
		join_none
		go(2'h0, 3'h1, 1'h0);
		chk("busy acquire", 32'h00000004, rd & 32'h00000004);
		chk("busy owner", 32'h1, {30'h0, ram.owner[1]});
		apb(1'h1, `DSEM_CFG_OFS, 32'h00000001);
		apb(1'h0, `DSEM_CFG_OFS, 32'h0);
		chk("cfg", 32'h00000001, rd);
		chk("master strap", 32'h1, {31'h0, role_master});
		// a low slave level must not reach the port once strapped master
		slave_busy_n <= 1'h0;
		@(posedge pclk);
		chk("master busy", 32'h1, {31'h0, busy_n});
		summarize();
	end
endmodule : dsem_host_test
bind dsem_host dsem_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pslverr(pslverr), .pins(pins), .busy_n(busy_n));
